/* File: core/pld_pkg.sv */
// shared constants and types of the digital lock detector
package pld_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS  = 50000;
    localparam int unsigned LOCK_WIN_HI_PS = 3500;
    localparam int unsigned LOCK_WIN_LO_PS = 2000;
    localparam int unsigned LOL_HI_PS      = 7000;
    localparam int unsigned LOL_LO_PS      = 4000;

    // longest times round down, never below one cycle
    function automatic int unsigned pld_ps2cyc(input int unsigned ps);
        int unsigned c;
        c = ps / CLK_PERIOD_PS;
        return (c == 0) ? 1 : c;
    endfunction : pld_ps2cyc

    localparam int unsigned MEAS_W = 8;
    localparam logic [7:0] WIN_HI_CYC = 8'(pld_ps2cyc(LOCK_WIN_HI_PS));
    localparam logic [7:0] WIN_LO_CYC = 8'(pld_ps2cyc(LOCK_WIN_LO_PS));
    localparam logic [7:0] LOL_HI_CYC = 8'(pld_ps2cyc(LOL_HI_PS));
    localparam logic [7:0] LOL_LO_CYC = 8'(pld_ps2cyc(LOL_LO_PS));

    // ------------------------------------------------------------
    // register map (byte addresses) and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_LDCTRL    = 8'h18;
    localparam logic [7:0] OFS_PDCTRL    = 8'h1C;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h20;
    localparam logic [7:0] OFS_IRQ_CLR   = 8'h24;
    localparam logic [7:0] OFS_IRQ_EN    = 8'h28;
    localparam logic [7:0] OFS_LOCK_STAT = 8'h2C;
    localparam logic [7:0] OFS_LOCK_CNT  = 8'h30;
    localparam logic [7:0] LDCTRL_RST    = 8'h00;
    localparam logic [7:0] PDCTRL_RST    = 8'h00;
    localparam logic [1:0] IRQ_EN_RST    = 2'h0;

    // field positions
    localparam int unsigned IRQ_LOCK_BIT = 0;
    localparam int unsigned IRQ_LOSS_BIT = 1;
    localparam int unsigned IRQ_W        = 2;

    // ------------------------------------------------------------
    // code tables
    // ------------------------------------------------------------
    localparam logic [7:0]  LOCK_CNT_00 = 8'h05;
    localparam logic [7:0]  LOCK_CNT_01 = 8'h10;
    localparam logic [7:0]  LOCK_CNT_10 = 8'h40;
    localparam logic [7:0]  LOCK_CNT_11 = 8'hFF;
    localparam logic [12:0] ABL_PS_2P9  = 13'h0B54;
    localparam logic [12:0] ABL_PS_1P3  = 13'h0514;
    localparam logic [12:0] ABL_PS_6P0  = 13'h1770;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       dc_off;
        logic [1:0] cnt_sel;
        logic       win_low;
        logic       dis;
        logic [2:0] rsv;
    } pld_ldctrl_t;

    typedef struct packed {
        logic              valid;
        logic [MEAS_W-1:0] diff;
    } pld_meas_t;

    typedef enum logic [2:0] {
        ST_OFF    = 3'b001,
        ST_ACQ    = 3'b010,
        ST_LOCKED = 3'b100
    } pld_state_t;

endpackage : pld_pkg

/* File: core/pld_edge_meas.sv */
// pin synchronisers and rising-edge spacing measurement of the two detector inputs
`timescale 1ns/1ps
module pld_edge_meas
    import pld_pkg::*;
#(
    parameter int unsigned CNT_W = 8
) (
    input  wire logic      clk_i,      // system clock
    input  wire logic      reset_n_i,  // async reset, active low
    input  wire logic      ref_pin_i,  // reference side, async
    input  wire logic      fb_pin_i,   // feedback side, async
    output pld_meas_t      meas_o      // one result per detector cycle
);

    if (CNT_W < 2 || CNT_W > MEAS_W) begin : g_chk
        $error("pld_edge_meas: CNT_W out of range");
    end

    // ------------------------------------------------------------
    // three-stage synchronisers, change taken when stages 2 and 3 agree
    // ------------------------------------------------------------
    logic [1:0] pin_w;
    logic [1:0] rise_reg;
    assign pin_w = {fb_pin_i, ref_pin_i};

    for (genvar g = 0; g < 2; g++) begin : g_sync
        logic [2:0] sync_reg;
        logic       lvl_reg;
        always_ff @(posedge clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                sync_reg    <= 3'h0;
                lvl_reg     <= 1'b0;
                rise_reg[g] <= 1'b0;
            end else begin
                sync_reg    <= {sync_reg[1:0], pin_w[g]};
                lvl_reg     <= (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : lvl_reg;
                rise_reg[g] <= (sync_reg[1] == sync_reg[2]) && sync_reg[2] && !lvl_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // edge pairing
    // ------------------------------------------------------------
    logic             wait_reg;
    logic             first_reg;
    logic [CNT_W-1:0] cnt_reg;
    pld_meas_t        meas_reg;

    // a lone edge or a saturated count reports the largest spacing
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wait_reg  <= 1'b0;
            first_reg <= 1'b0;
            cnt_reg   <= '0;
            meas_reg  <= '0;
        end else begin
            meas_reg.valid <= 1'b0;
            if (!wait_reg) begin
                if (&rise_reg) begin
                    meas_reg <= '{valid: 1'b1, diff: '0};
                end else if (|rise_reg) begin
                    wait_reg  <= 1'b1;
                    first_reg <= rise_reg[1];
                    cnt_reg   <= CNT_W'(1);
                end
            end else if (rise_reg[!first_reg]) begin
                meas_reg <= '{valid: 1'b1, diff: MEAS_W'(cnt_reg)};
                wait_reg <= 1'b0;
            end else if (rise_reg[first_reg] || (&cnt_reg)) begin
                meas_reg <= '{valid: 1'b1, diff: {MEAS_W{1'b1}}};
                wait_reg <= rise_reg[first_reg];
                cnt_reg  <= CNT_W'(1);
            end else begin
                cnt_reg <= cnt_reg + CNT_W'(1);
            end
        end
    end

    assign meas_o = meas_reg;

endmodule : pld_edge_meas

/* File: core/pld_lock_detect.sv */
// digital lock detector with phase-detector settings and Avalon-MM registers
`timescale 1ns/1ps
module pld_lock_detect
    import pld_pkg::*;
(
    input  wire logic        clk_i,              // 20 MHz system clock
    input  wire logic        reset_n_i,          // async reset, active low
    input  wire logic [7:0]  avs_address_i,      // byte address
    input  wire logic        avs_read_i,         // read request
    input  wire logic        avs_write_i,        // write request
    input  wire logic [31:0] avs_writedata_i,    // write data
    input  wire logic [3:0]  avs_byteenable_i,   // byte lanes
    output logic      [31:0] avs_readdata_o,     // read data
    output logic             avs_waitrequest_o,  // stall
    input  wire logic        ref_pin_i,          // detector reference edge
    input  wire logic        fb_pin_i,           // detector feedback edge
    output logic             digital_lock_flag_o,// lock indication
    output logic             ref_dc_offset_en_o, // CMOS input offset enable
    output logic      [1:0]  abl_sel_o,          // antibacklash code
    output logic      [12:0] abl_width_ps_o,     // antibacklash width, ps
    output logic             irq_o               // level interrupt
);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] lock_target(input logic [1:0] sel);
        unique case (sel)
            2'b00: return LOCK_CNT_00;
            2'b01: return LOCK_CNT_01;
            2'b10: return LOCK_CNT_10;
            2'b11: return LOCK_CNT_11;
        endcase
    endfunction : lock_target

    function automatic logic [12:0] abl_ps(input logic [1:0] code);
        unique case (code)
            2'b00:   return ABL_PS_2P9;
            2'b01:   return ABL_PS_1P3;
            2'b10:   return ABL_PS_6P0;
            2'b11:   return ABL_PS_2P9;
        endcase
    endfunction : abl_ps

    // ------------------------------------------------------------
    // edge measurement
    // ------------------------------------------------------------
    pld_meas_t meas;

    pld_edge_meas #(
        .CNT_W (MEAS_W)
    ) u_meas (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .ref_pin_i (ref_pin_i),
        .fb_pin_i  (fb_pin_i),
        .meas_o    (meas)
    );

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    logic             wait_reg;
    logic [31:0]      rdata_reg;
    logic [7:0]       rd_byte;
    logic             wr_take;
    pld_ldctrl_t      ld_reg;
    logic [7:0]       pd_reg;
    logic [IRQ_W-1:0] stat_reg;
    logic [IRQ_W-1:0] stat_next;
    logic [IRQ_W-1:0] en_reg;
    logic [IRQ_W-1:0] en_next;
    logic [IRQ_W-1:0] clr_w;
    logic [IRQ_W-1:0] ev_w;
    pld_state_t       state_reg;
    logic [7:0]       cnt_reg;
    logic             flag_reg;

    // every access answers one cycle after it is seen
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wait_reg <= 1'b1;
        end else if ((avs_read_i || avs_write_i) && wait_reg) begin
            wait_reg <= 1'b0;
        end else begin
            wait_reg <= 1'b1;
        end
    end

    assign wr_take = avs_write_i && !wait_reg && avs_byteenable_i[0];

    always_comb begin
        unique case (avs_address_i)
            OFS_LDCTRL:    rd_byte = {ld_reg.dc_off, ld_reg.cnt_sel, ld_reg.win_low, ld_reg.dis, 3'h0};
            OFS_PDCTRL:    rd_byte = {6'h00, pd_reg[1:0]};
            OFS_IRQ_STAT:  rd_byte = {6'h00, stat_reg};
            OFS_IRQ_EN:    rd_byte = {6'h00, en_reg};
            OFS_LOCK_STAT: rd_byte = {5'h00, state_reg == ST_ACQ, state_reg == ST_OFF, flag_reg};
            OFS_LOCK_CNT:  rd_byte = cnt_reg;
            default:       rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (avs_read_i && wait_reg) begin
            rdata_reg <= {24'h00_0000, rd_byte};
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // low three bits belong to other functions and read as zero
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ld_reg <= LDCTRL_RST;
        end else if (wr_take && avs_address_i == OFS_LDCTRL) begin
            ld_reg <= {avs_writedata_i[7:3], 3'h0};
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pd_reg <= PDCTRL_RST;
        end else if (wr_take && avs_address_i == OFS_PDCTRL) begin
            pd_reg <= {6'h00, avs_writedata_i[1:0]};
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ref_dc_offset_en_o <= 1'b0;
            abl_sel_o          <= 2'h0;
            abl_width_ps_o     <= ABL_PS_2P9;
        end else begin
            ref_dc_offset_en_o <= ld_reg.dc_off;
            abl_sel_o          <= pd_reg[1:0];
            abl_width_ps_o     <= abl_ps(pd_reg[1:0]);
        end
    end

    // ------------------------------------------------------------
    // lock detection
    // ------------------------------------------------------------
    logic [7:0] target_w;
    logic [7:0] win_cyc;
    logic [7:0] lol_cyc;
    logic       in_win;
    logic       over_lol;
    logic       reach;

    assign target_w = lock_target(ld_reg.cnt_sel);
    assign win_cyc  = ld_reg.win_low ? WIN_LO_CYC : WIN_HI_CYC;
    assign lol_cyc  = ld_reg.win_low ? LOL_LO_CYC : LOL_HI_CYC;
    assign in_win   = meas.valid && (meas.diff < win_cyc);
    assign over_lol = meas.valid && (meas.diff > lol_cyc);
    // compare one wider so 255 is reachable; a lowered target locks on the next in-window cycle
    assign reach    = ({1'b0, cnt_reg} + 9'h001) >= {1'b0, target_w};

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= ST_ACQ;
            cnt_reg   <= 8'h00;
            flag_reg  <= 1'b0;
        end else if (ld_reg.dis) begin
            state_reg <= ST_OFF;
            cnt_reg   <= 8'h00;
            flag_reg  <= 1'b0;
        end else begin
            unique case (state_reg)
                ST_OFF: begin
                    state_reg <= ST_ACQ;
                    cnt_reg   <= 8'h00;
                end
                ST_ACQ: begin
                    if (in_win && reach) begin
                        state_reg <= ST_LOCKED;
                        cnt_reg   <= target_w;
                        flag_reg  <= 1'b1;
                    end else if (in_win) begin
                        cnt_reg <= cnt_reg + 8'h01;
                    end else if (meas.valid) begin
                        cnt_reg <= 8'h00;
                    end
                end
                ST_LOCKED: begin
                    if (over_lol) begin
                        state_reg <= ST_ACQ;
                        cnt_reg   <= 8'h00;
                        flag_reg  <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    assign ev_w[IRQ_LOCK_BIT] = !ld_reg.dis && state_reg == ST_ACQ && in_win && reach;
    assign ev_w[IRQ_LOSS_BIT] = state_reg == ST_LOCKED && (ld_reg.dis || over_lol);
    assign clr_w     = (wr_take && avs_address_i == OFS_IRQ_CLR) ? avs_writedata_i[IRQ_W-1:0] : '0;
    // a new event wins over a clear in the same cycle
    assign stat_next = (stat_reg & ~clr_w) | ev_w;
    assign en_next   = (wr_take && avs_address_i == OFS_IRQ_EN) ? avs_writedata_i[IRQ_W-1:0] : en_reg;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            stat_reg <= '0;
            en_reg   <= IRQ_EN_RST;
            irq_o    <= 1'b0;
        end else begin
            stat_reg <= stat_next;
            en_reg   <= en_next;
            irq_o    <= |(stat_next & en_next);
        end
    end

    assign avs_waitrequest_o   = wait_reg;
    assign avs_readdata_o      = rdata_reg;
    assign digital_lock_flag_o = flag_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence s_acq_hit;
        !ld_reg.dis && state_reg == ST_ACQ && in_win;
    endsequence

    sequence s_locked_miss;
        digital_lock_flag_o && !ld_reg.dis && meas.valid && meas.diff > lol_cyc;
    endsequence

    AST_ABL_6P0: assert property ((pd_reg[1:0] == 2'b10) [*2] |-> abl_width_ps_o == ABL_PS_6P0)
        else $error("antibacklash width wrong for code 10");
    AST_ABL_11: assert property ((pd_reg[1:0] == 2'b11) [*2] |-> abl_width_ps_o == ABL_PS_2P9)
        else $error("antibacklash width wrong for code 11");
    AST_DC_OFFSET: assert property (ld_reg.dc_off ##1 ld_reg.dc_off |-> ref_dc_offset_en_o)
        else $error("dc offset not applied");
    AST_LOCK_COUNT: assert property ($rose(digital_lock_flag_o) |-> $past(state_reg) == ST_ACQ
        && ({1'b0, $past(cnt_reg)} + 9'h001) >= {1'b0, $past(target_w)})
        else $error("lock flag rose before count reached");
    AST_COUNT_UP: assert property (s_acq_hit ##0 !reach |=> cnt_reg == $past(cnt_reg) + 8'h01)
        else $error("in-window cycle not counted");
    AST_HOLD: assert property (digital_lock_flag_o && !ld_reg.dis && !over_lol |=> digital_lock_flag_o)
        else $error("lock flag dropped without loss");
    AST_LOSS: assert property (s_locked_miss |=> !digital_lock_flag_o && state_reg == ST_ACQ)
        else $error("lock flag held past loss threshold");
    AST_WIN_HIGH: assert property (!ld_reg.dis && !ld_reg.win_low && state_reg == ST_ACQ
        && meas.valid && meas.diff >= WIN_HI_CYC |=> cnt_reg == 8'h00)
        else $error("high range window not applied");
    AST_DISABLE: assert property (ld_reg.dis |=> !digital_lock_flag_o && state_reg == ST_OFF)
        else $error("detector runs while disabled");
    AST_RESTART: assert property (state_reg == ST_ACQ && meas.valid && !in_win |=> cnt_reg == 8'h00)
        else $error("count not restarted");
    AST_IRQ_LEVEL: assert property (irq_o == |(stat_reg & en_reg))
        else $error("interrupt level mismatch");
    AST_BUS_ANSWER: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("bus answer timing wrong");

    // ------------------------------------------------------------
    // status and register checks
    // ------------------------------------------------------------
    sequence s_flag_up;
        !digital_lock_flag_o ##1 digital_lock_flag_o;
    endsequence

    AST_LOCK_STATE: assert property (s_flag_up |-> state_reg == ST_LOCKED && cnt_reg == $past(target_w))
        else $error("lock state or count wrong at lock");
    AST_LOCK_EVENT: assert property ($rose(digital_lock_flag_o) |-> stat_reg[IRQ_LOCK_BIT])
        else $error("lock status bit not set");
    AST_LOSS_EVENT: assert property ($fell(digital_lock_flag_o) |-> stat_reg[IRQ_LOSS_BIT])
        else $error("loss status bit not set");
    AST_LOCK_STICKY: assert property (stat_reg[IRQ_LOCK_BIT] && !clr_w[IRQ_LOCK_BIT] |=> stat_reg[IRQ_LOCK_BIT])
        else $error("lock status bit dropped without clear");
    AST_LOSS_STICKY: assert property (stat_reg[IRQ_LOSS_BIT] && !clr_w[IRQ_LOSS_BIT] |=> stat_reg[IRQ_LOSS_BIT])
        else $error("loss status bit dropped without clear");
    AST_WIN_LOW: assert property (!ld_reg.dis && ld_reg.win_low && state_reg == ST_ACQ
        && meas.valid && meas.diff >= WIN_LO_CYC |=> cnt_reg == 8'h00)
        else $error("low range window not applied");
    AST_REARM: assert property (state_reg == ST_OFF && !ld_reg.dis
        |=> state_reg == ST_ACQ && cnt_reg == 8'h00)
        else $error("detector did not restart after enable");
    AST_LANE_OFF: assert property (avs_write_i && !avs_byteenable_i[0]
        |=> $stable(ld_reg) && $stable(pd_reg) && $stable(en_reg))
        else $error("write with low lane off changed a register");
    AST_READ_DATA: assert property (avs_read_i && avs_waitrequest_o
        |=> avs_readdata_o == {24'h00_0000, $past(rd_byte)})
        else $error("read data not loaded");

endmodule : pld_lock_detect

/* File: tb/testbench.sv */
// self-checking testbench of the digital lock detector, driven over its register bus
`timescale 1ns/1ps
module testbench;
    import pld_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        clk_i;
    logic        reset_n_i;
    logic [7:0]  avs_address_i;
    logic        avs_read_i;
    logic        avs_write_i;
    logic [31:0] avs_writedata_i;
    logic [3:0]  avs_byteenable_i;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        ref_pin_i;
    logic        fb_pin_i;
    logic        digital_lock_flag_o;
    logic        ref_dc_offset_en_o;
    logic [1:0]  abl_sel_o;
    logic [12:0] abl_width_ps_o;
    logic        irq_o;
    int          n_fail;
    int          tests_run;
    logic [31:0] rd;
    logic [7:0]  tgt [4] = '{LOCK_CNT_00, LOCK_CNT_01, LOCK_CNT_10, LOCK_CNT_11};
    logic [12:0] abl [4] = '{ABL_PS_2P9, ABL_PS_1P3, ABL_PS_6P0, ABL_PS_2P9};

    pld_lock_detect DUT (
        .clk_i               (clk_i),
        .reset_n_i           (reset_n_i),
        .avs_address_i       (avs_address_i),
        .avs_read_i          (avs_read_i),
        .avs_write_i         (avs_write_i),
        .avs_writedata_i     (avs_writedata_i),
        .avs_byteenable_i    (avs_byteenable_i),
        .avs_readdata_o      (avs_readdata_o),
        .avs_waitrequest_o   (avs_waitrequest_o),
        .ref_pin_i           (ref_pin_i),
        .fb_pin_i            (fb_pin_i),
        .digital_lock_flag_o (digital_lock_flag_o),
        .ref_dc_offset_en_o  (ref_dc_offset_en_o),
        .abl_sel_o           (abl_sel_o),
        .abl_width_ps_o      (abl_width_ps_o),
        .irq_o               (irq_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic stop_test;
        if (n_fail == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one Avalon transfer; request held until waitrequest is sampled low, a hang is left to the watchdog
    task automatic bus(input logic wr, input logic [7:0] adr, input logic [7:0] wd, input logic [3:0] be,
                       output logic [31:0] data);
        @(posedge clk_i);
        avs_address_i    <= adr;
        avs_read_i       <= ~wr;
        avs_write_i      <= wr;
        avs_writedata_i  <= {24'h000000, wd};
        avs_byteenable_i <= be;
        @(posedge clk_i);
        while (avs_waitrequest_o !== 1'b0) begin
            @(posedge clk_i);
        end
        data = avs_readdata_o;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
    endtask : bus

    task automatic wr_reg(input logic [7:0] adr, input logic [7:0] wd);
        logic [31:0] dummy;
        bus(1'b1, adr, wd, 4'hF, dummy);
    endtask : wr_reg

    task automatic rd_chk(input string what, input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] got;
        bus(1'b0, adr, 8'h00, 4'hF, got);
        chk(what, exp, got);
    endtask : rd_chk

    // registered outputs trail a write by a cycle or two
    task automatic settle;
        repeat (3) @(posedge clk_i);
    endtask : settle

    // one detector cycle: fb rises d cycles after ref, each level held >= 4 cycles
    task automatic pd(input int d);
        @(posedge clk_i);
        ref_pin_i <= 1'b1;
        repeat (d) @(posedge clk_i);
        fb_pin_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        ref_pin_i <= 1'b0;
        repeat (d) @(posedge clk_i);
        fb_pin_i <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask : pd

    task automatic pds(input int n, input int d);
        repeat (n) pd(d);
    endtask : pds

    // ------------------------------------------------------------
    // watchdog: the whole sequence needs well under 10000 cycles
    // ------------------------------------------------------------
    initial begin
        repeat (40000) @(posedge clk_i);
        n_fail++;
        $display("[FAIL] watchdog expected done seen running");
        stop_test();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        n_fail = 0;
        tests_run = 0;
        reset_n_i = 1'b0;
        avs_address_i = 8'h00;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_writedata_i = 32'h00000000;
        avs_byteenable_i = 4'h0;
        ref_pin_i = 1'b0;
        fb_pin_i = 1'b0;
        repeat (4) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(posedge clk_i);
        chk("lock flag", 32'(1'b0), 32'(digital_lock_flag_o));
        chk("dc offset", 32'(1'b0), 32'(ref_dc_offset_en_o));
        chk("abl width", 32'(ABL_PS_2P9), 32'(abl_width_ps_o));
        chk("irq", 32'(1'b0), 32'(irq_o));
        rd_chk("ldctrl", OFS_LDCTRL, 32'(LDCTRL_RST));
        rd_chk("pdctrl", OFS_PDCTRL, 32'(PDCTRL_RST));
        rd_chk("irq en", OFS_IRQ_EN, 32'(IRQ_EN_RST));
        rd_chk("lock stat", OFS_LOCK_STAT, 32'h00000004);
        // refused accesses
        wr_reg(8'h40, 8'hFF);
        rd_chk("unmapped", 8'h40, 32'h00000000);
        rd_chk("irq clr", OFS_IRQ_CLR, 32'h00000000);
        // dc offset bit, and a write with the low lane off
        wr_reg(OFS_LDCTRL, 8'h80);
        settle();
        chk("dc offset on", 32'(1'b1), 32'(ref_dc_offset_en_o));
        rd_chk("ldctrl dc", OFS_LDCTRL, 32'h00000080);
        wr_reg(OFS_LDCTRL, 8'h00);
        bus(1'b1, OFS_LDCTRL, 8'h80, 4'hE, rd);
        settle();
        chk("dc offset off", 32'(1'b0), 32'(ref_dc_offset_en_o));
        // every antibacklash code
        for (int k = 0; k < 4; k++) begin
            wr_reg(OFS_PDCTRL, 8'(k));
            settle();
            chk("abl sel", 32'(k), 32'(abl_sel_o));
            chk("abl width", 32'(abl[k]), 32'(abl_width_ps_o));
        end
        // lock with restart, hold in hysteresis band, loss, interrupt handling
        wr_reg(OFS_IRQ_EN, 8'h03);
        pds(4, 0);
        pd(3);
        rd_chk("lock cnt restart", OFS_LOCK_CNT, 32'h00000000);
        pds(4, 0);
        rd_chk("lock cnt four", OFS_LOCK_CNT, 32'h00000004);
        chk("flag after restart", 32'(1'b0), 32'(digital_lock_flag_o));
        chk("irq before lock", 32'(1'b0), 32'(irq_o));
        pd(0);
        chk("flag locked", 32'(1'b1), 32'(digital_lock_flag_o));
        chk("irq on lock", 32'(1'b1), 32'(irq_o));
        rd_chk("irq stat lock", OFS_IRQ_STAT, 32'h00000001);
        rd_chk("lock stat lock", OFS_LOCK_STAT, 32'h00000001);
        pd(1);
        chk("flag held", 32'(1'b1), 32'(digital_lock_flag_o));
        pd(2);
        chk("flag lost", 32'(1'b0), 32'(digital_lock_flag_o));
        rd_chk("irq stat loss", OFS_IRQ_STAT, 32'h00000003);
        wr_reg(OFS_IRQ_EN, 8'h00);
        settle();
        chk("irq masked", 32'(1'b0), 32'(irq_o));
        wr_reg(OFS_IRQ_EN, 8'h03);
        settle();
        chk("irq unmasked", 32'(1'b1), 32'(irq_o));
        wr_reg(OFS_IRQ_CLR, 8'h03);
        settle();
        chk("irq cleared", 32'(1'b0), 32'(irq_o));
        rd_chk("irq stat clr", OFS_IRQ_STAT, 32'h00000000);
        // every count code, both window ranges; a wide cycle first restarts the count
        for (int k = 0; k < 4; k++) begin
            wr_reg(OFS_LDCTRL, {1'b0, 2'(k), 1'(k), 4'h0});
            pd(3);
            pds(int'(tgt[k]) - 1, 0);
            chk("flag one short", 32'(1'b0), 32'(digital_lock_flag_o));
            pd(0);
            chk("flag at count", 32'(1'b1), 32'(digital_lock_flag_o));
        end
        // disabling while locked
        wr_reg(OFS_IRQ_CLR, 8'h03);
        wr_reg(OFS_LDCTRL, 8'h08);
        settle();
        chk("flag disabled", 32'(1'b0), 32'(digital_lock_flag_o));
        pds(6, 0);
        chk("flag stays off", 32'(1'b0), 32'(digital_lock_flag_o));
        rd_chk("lock stat dis", OFS_LOCK_STAT, 32'h00000002);
        rd_chk("irq stat dis", OFS_IRQ_STAT, 32'h00000002);
        wr_reg(OFS_LDCTRL, 8'h00);
        pds(5, 0);
        chk("flag re-enabled", 32'(1'b1), 32'(digital_lock_flag_o));
        stop_test();
    end
endmodule : testbench
